// >>> design/fsw_escape_decode.sv
// Classifies an instruction opcode for the status logic.
// Assumes the opcode arrives already recognised as an escape by the host.
`timescale 1ns/1ps
`include "fsw_params.svh"

module fsw_escape_decode
    import fsw_pkg::*;
(
    // Opcode
    input wire logic [15:0] i_opcode,
    input wire logic i_opcode_valid,
    // Class
    output fsw_op_t o_op,
    output logic o_is_escape
);

    // ****************************************
    // Decode
    // ****************************************
    always_comb begin
        o_is_escape = (i_opcode[15:11] == `FSW_ESCAPE_PATTERN);
        o_op = FSW_OP_NONE;
        if (i_opcode_valid && o_is_escape) begin
            if (i_opcode == 16'hdbe3) begin
                o_op = FSW_OP_INIT;
            end else if (i_opcode == 16'hdbe2) begin
                o_op = FSW_OP_CLEAR_EXC;
            end else if (i_opcode == 16'hdfe0) begin
                o_op = FSW_OP_STORE_STATUS_ACC;
            end else if (i_opcode == 16'hded9) begin
                o_op = FSW_OP_COMPARE_POP2;
            end else if (i_opcode[15:8] == 8'hd9 && i_opcode[7:3] == 5'h1d) begin
                o_op = FSW_OP_CONST_LOAD;
            end else if (i_opcode[15:8] == 8'hd9 && i_opcode[7:4] == 4'hf) begin
                o_op = FSW_OP_TRANSCEND;
            end else if (i_opcode[15:8] == 8'hd8 && i_opcode[7:4] == 4'hd) begin
                o_op = FSW_OP_COMPARE;
            end else if (i_opcode[15:8] == 8'hd9 && i_opcode[5:3] == 3'h4) begin
                o_op = FSW_OP_LOAD_ENV;
            end else if (i_opcode[15:8] == 8'hdd && i_opcode[5:3] == 3'h6) begin
                o_op = FSW_OP_SAVE_STATE;
            end else if (i_opcode[15:8] == 8'hdd && i_opcode[5:3] == 3'h4) begin
                o_op = FSW_OP_RESTORE_STATE;
            end else if (i_opcode[15:8] == 8'hdd && i_opcode[5:3] == 3'h7) begin
                o_op = FSW_OP_STORE_STATUS;
            end else if (i_opcode[15:8] == 8'hd8) begin
                o_op = FSW_OP_ARITH;
            end else begin
                o_op = FSW_OP_OTHER;
            end
        end
    end

endmodule : fsw_escape_decode

// >>> design/fsw_idle_ctrl.sv
// Automatic idle control of the execution unit.
// Assumes done and start are synchronous to i_clk.
`timescale 1ns/1ps
`include "fsw_params.svh"

module fsw_idle_ctrl
    import fsw_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Activity
    input wire logic i_clock_mode_select,
    input wire logic i_instr_start,
    input wire logic i_instr_done,
    // Power
    output logic o_exec_enable,
    output logic o_idle
);

    typedef enum logic [1:0] {ST_ACTIVE, ST_COUNT, ST_IDLE} fsw_idle_state_t;

    fsw_idle_state_t state;
    logic [1:0] count;

    // ****************************************
    // Idle sequencer
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_ACTIVE;
            count <= 2'h0;
        end else begin
            case (state)
                ST_ACTIVE: begin
                    if (i_instr_done && i_clock_mode_select) begin
                        state <= ST_COUNT;
                        count <= 2'h1;
                    end
                end
                ST_COUNT: begin
                    if (i_instr_start || !i_clock_mode_select) begin
                        state <= ST_ACTIVE;
                    end else if (count == 2'(`FSW_IDLE_DELAY_CLOCKS)) begin
                        state <= ST_IDLE;
                    end else begin
                        count <= count + 2'h1;
                    end
                end
                ST_IDLE: begin
                    // Wake in the cycle after the instruction arrives
                    if (i_instr_start || !i_clock_mode_select) begin
                        state <= ST_ACTIVE;
                    end
                end
                default: begin
                    state <= ST_ACTIVE;
                end
            endcase
        end
    end

    // Async mode never idles, even mid-count
    assign o_idle = (state == ST_IDLE) && i_clock_mode_select;
    assign o_exec_enable = !o_idle;

endmodule : fsw_idle_ctrl

// >>> design/fsw_params.svh
// Constants for the coprocessor status-word block.
// Assumes inclusion by the package and the design modules only.
`ifndef FSW_PARAMS_SVH
`define FSW_PARAMS_SVH

// ****************************************
// Status word fields
// ****************************************
`define FSW_BIT_BUSY_MIRROR 15
`define FSW_BIT_C3 14
`define FSW_TOP_HI 13
`define FSW_TOP_LO 11
`define FSW_BIT_C2 10
`define FSW_BIT_C1 9
`define FSW_BIT_C0 8
`define FSW_BIT_ES 7
`define FSW_BIT_SF 6
`define FSW_EXC_HI 5
`define FSW_EXC_LO 0
`define FSW_INVALID_BIT 0
`define FSW_RESET_WORD 16'h0000
`define FSW_RESET_MASKS 6'h3f

// ****************************************
// Timing and escape pattern
// ****************************************
`define FSW_CLK_PERIOD_NS 40
`define FSW_IDLE_DELAY_CLOCKS 3
`define FSW_WAKE_CLOCKS 1
`define FSW_ESCAPE_PATTERN 5'h1b

`endif

// >>> design/fsw_pkg.sv
// Types for the coprocessor status-word block.
// Assumes fsw_params.svh is on the include path.
`include "fsw_params.svh"

package fsw_pkg;

    // ****************************************
    // Instruction classes seen by the status logic
    // ****************************************
    typedef enum logic [3:0] {
        FSW_OP_NONE,
        FSW_OP_ARITH,
        FSW_OP_COMPARE,
        FSW_OP_COMPARE_POP2,
        FSW_OP_CONST_LOAD,
        FSW_OP_TRANSCEND,
        FSW_OP_STORE_STATUS,
        FSW_OP_STORE_STATUS_ACC,
        FSW_OP_INIT,
        FSW_OP_CLEAR_EXC,
        FSW_OP_LOAD_ENV,
        FSW_OP_SAVE_STATE,
        FSW_OP_RESTORE_STATE,
        FSW_OP_OTHER
    } fsw_op_t;

    // Completion report from the execution datapath
    typedef struct packed {
        logic valid;
        logic [5:0] exc;
        logic cc_write;
        logic [3:0] cc;
        logic stack_fault;
        logic overflow;
        logic push;
        logic [1:0] pops;
    } fsw_result_t;

    // Status word as loaded from memory
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } fsw_load_t;

    // Status word read out
    typedef struct packed {
        logic valid;
        logic to_acc;
        logic [15:0] word;
    } fsw_store_t;

endpackage : fsw_pkg

// >>> design/fsw_status_word.sv
// Status word, exception summary and fault output of the coprocessor.
// Assumes the datapath reports each completed instruction for one cycle.
// Operation
// - Asynchronous clock mode never enters automatic idle; execution stays running.
// - Synchronous mode idles three clocks after completion, wakes within one clock.
// - A 16-bit status word is readable by store-status instructions.
// - Bit 15 always mirrors the error summary bit, never the busy output.
// - Bits 13 to 11 hold the stack top pointer.
// - Condition codes at bits 14 and 10 to 8 follow arithmetic outcomes.
// - Error summary is set when any unmasked exception flag is set.
// - The active-low fault output is asserted while error summary is set.
// - Stack-fault flag bit 6 marks invalid operations from stack over/underflow.
// - With stack fault, condition bit one is 1 on overflow, 0 on underflow.
// - Six sticky exception flags in bits 5 to 0 stay set until cleared.
// - Only init, clear, load-env, save and restore may clear the flags.
// - On status load, bits 7 and 15 are recomputed from flags and masks.
// - A load leaving error summary set asserts the fault output at once.
// - Comparisons report results only through the condition code bits.
// - Constant loads push one constant; only error is overflow invalid.
// - Transcendental results go back to the stack; radians and base 2.
// - A store-status variant sends the word straight to the host accumulator.
// - Pop-twice instructions remove two stack elements after the operation.
`timescale 1ns/1ps
`include "fsw_params.svh"

module fsw_status_word
    import fsw_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Mode
    input wire logic i_clock_mode_select,
    // Instruction from host
    input wire logic [15:0] i_opcode,
    input wire logic i_opcode_valid,
    // Masks from the control word
    input wire logic [5:0] i_exc_mask,
    // Datapath completion and load data
    input wire fsw_result_t i_result,
    input wire fsw_load_t i_load,
    // Status out
    output fsw_store_t o_store,
    output logic [15:0] o_fpu_status_word,
    output logic o_error_n,
    // Power and escape detect
    output logic o_exec_enable,
    output logic o_idle,
    output logic o_escape_seen
);

    // ****************************************
    // State
    // ****************************************
    fsw_op_t op;
    fsw_op_t pending_op;
    logic busy;
    logic [2:0] stack_top;
    logic [3:0] cond_codes;
    logic stack_fault_flag;
    logic [5:0] exc_flags;
    logic error_summary_bit;
    logic [15:0] status_view;
    logic instr_done;
    logic next_summary;
    logic [5:0] next_exc;
    logic [3:0] next_cc;
    logic next_sf;
    logic [2:0] next_top;
    logic clear_exc;

    fsw_escape_decode u_decode (
        .i_opcode(i_opcode),
        .i_opcode_valid(i_opcode_valid),
        .o_op(op),
        .o_is_escape(o_escape_seen)
    );

    fsw_idle_ctrl u_idle (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clock_mode_select(i_clock_mode_select),
        .i_instr_start(op != FSW_OP_NONE),
        .i_instr_done(instr_done),
        .o_exec_enable(o_exec_enable),
        .o_idle(o_idle)
    );

    // Summary of unmasked exceptions
    function automatic logic summary_of(input logic [5:0] flags, input logic [5:0] masks);
        summary_of = |(flags & ~masks);
    endfunction : summary_of

    // ****************************************
    // Instruction tracking
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy <= 1'b0;
            pending_op <= FSW_OP_NONE;
        end else begin
            if (op != FSW_OP_NONE) begin
                busy <= 1'b1;
                pending_op <= op;
            end else if (instr_done) begin
                busy <= 1'b0;
                pending_op <= FSW_OP_NONE;
            end
        end
    end

    // Init, clear, store and save finish locally; other ops finish on a result or load strobe
    assign instr_done = busy && (i_result.valid || i_load.valid ||
        pending_op == FSW_OP_INIT || pending_op == FSW_OP_CLEAR_EXC ||
        pending_op == FSW_OP_STORE_STATUS || pending_op == FSW_OP_STORE_STATUS_ACC ||
        pending_op == FSW_OP_SAVE_STATE);

    // ****************************************
    // Next status fields
    // ****************************************
    always_comb begin
        next_exc = exc_flags;
        next_cc = cond_codes;
        next_sf = stack_fault_flag;
        next_top = stack_top;
        clear_exc = busy && (pending_op == FSW_OP_INIT ||
            pending_op == FSW_OP_CLEAR_EXC || pending_op == FSW_OP_SAVE_STATE);
        if (clear_exc) begin
            next_exc = 6'h00;
            next_sf = 1'b0;
        end
        if (busy && pending_op == FSW_OP_INIT) begin
            next_top = 3'h0;
            next_cc = 4'h0;
        end
        if (busy && i_load.valid &&
            (pending_op == FSW_OP_LOAD_ENV || pending_op == FSW_OP_RESTORE_STATE)) begin
            next_exc = i_load.word[`FSW_EXC_HI:`FSW_EXC_LO];
            next_sf = i_load.word[`FSW_BIT_SF];
            next_top = i_load.word[`FSW_TOP_HI:`FSW_TOP_LO];
            next_cc = {i_load.word[`FSW_BIT_C3], i_load.word[`FSW_BIT_C2],
                i_load.word[`FSW_BIT_C1], i_load.word[`FSW_BIT_C0]};
        end else if (busy && i_result.valid) begin
            // Sticky: OR new events in, never clear
            next_exc = next_exc | i_result.exc;
            if (pending_op == FSW_OP_CONST_LOAD) begin
                // Only overflow invalid can arise
                next_exc = next_exc & 6'h01;
                next_exc = next_exc | exc_flags;
            end
            if (i_result.cc_write) begin
                next_cc = i_result.cc;
            end
            if (i_result.stack_fault) begin
                next_sf = 1'b1;
                next_exc[`FSW_INVALID_BIT] = 1'b1;
                next_cc[1] = i_result.overflow;
            end
            if (i_result.push) begin
                next_top = stack_top - 3'h1;
            end
            if (pending_op == FSW_OP_COMPARE_POP2) begin
                next_top = next_top + 3'h2;
            end else begin
                next_top = next_top + {1'b0, i_result.pops};
            end
        end
        // Recomputed, never taken from memory
        next_summary = summary_of(next_exc, i_exc_mask);
    end

    // ****************************************
    // Exception flags and stack fault
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            exc_flags <= 6'h00;
            stack_fault_flag <= 1'b0;
        end else begin
            exc_flags <= next_exc;
            stack_fault_flag <= next_sf;
        end
    end

    // ****************************************
    // Condition codes and stack top
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cond_codes <= 4'h0;
            stack_top <= 3'h0;
        end else begin
            cond_codes <= next_cc;
            stack_top <= next_top;
        end
    end

    // ****************************************
    // Error summary and fault pin
    // ****************************************
    // Also tracks mask changes so the pin follows the control word
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            error_summary_bit <= 1'b0;
            o_error_n <= 1'b1;
        end else begin
            error_summary_bit <= next_summary;
            o_error_n <= !next_summary;
        end
    end

    // ****************************************
    // Status word assembly
    // ****************************************
    always_comb begin
        status_view = `FSW_RESET_WORD;
        status_view[`FSW_BIT_BUSY_MIRROR] = error_summary_bit;
        status_view[`FSW_BIT_C3] = cond_codes[3];
        status_view[`FSW_TOP_HI:`FSW_TOP_LO] = stack_top;
        status_view[`FSW_BIT_C2] = cond_codes[2];
        status_view[`FSW_BIT_C1] = cond_codes[1];
        status_view[`FSW_BIT_C0] = cond_codes[0];
        status_view[`FSW_BIT_ES] = error_summary_bit;
        status_view[`FSW_BIT_SF] = stack_fault_flag;
        status_view[`FSW_EXC_HI:`FSW_EXC_LO] = exc_flags;
    end

    assign o_fpu_status_word = status_view;

    // ****************************************
    // Store-status output
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_store <= '0;
        end else begin
            o_store.valid <= busy && (pending_op == FSW_OP_STORE_STATUS ||
                pending_op == FSW_OP_STORE_STATUS_ACC);
            o_store.to_acc <= pending_op == FSW_OP_STORE_STATUS_ACC;
            o_store.word <= status_view;
        end
    end

endmodule : fsw_status_word

// >>> testbench/fsw_host_model.sv
// Host and datapath side: issues escape opcodes and completion reports.
// Assumes the caller waits for each instruction to finish before the next.
`timescale 1ns/1ps

module fsw_host_model
    import fsw_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Toward the block
    output logic [15:0] o_opcode,
    output logic o_opcode_valid,
    output fsw_result_t o_result,
    output fsw_load_t o_load
);
    initial begin
        o_opcode = 16'h0000;
        o_opcode_valid = 1'b0;
        o_result = '0;
        o_load = '0;
    end

    // Status word read back from memory, one-cycle strobe
    task load(input logic [15:0] w);
        @(negedge i_clk);
        o_load.word = w;
        o_load.valid = 1'b1;
        @(negedge i_clk);
        o_load = '0;
    endtask : load

    // Only escape-coded words are forwarded; others stay on the host
    task issue(input logic [15:0] op);
        if (op[15:11] == 5'h1b) begin
            @(negedge i_clk);
            o_opcode = op;
            o_opcode_valid = 1'b1;
            @(negedge i_clk);
            o_opcode_valid = 1'b0;
            o_opcode = ~op;
        end
    endtask : issue

    // Report completion after a chosen number of busy cycles
    task complete(input fsw_result_t r, input int delay);
        repeat (delay) @(negedge i_clk);
        o_result = r;
        o_result.valid = 1'b1;
        @(negedge i_clk);
        o_result = '0;
    endtask : complete
endmodule : fsw_host_model

// >>> testbench/fsw_status_word_props.sv
// Checker for the status-word block, watching its ports only.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/1ps

module fsw_status_word_props
    import fsw_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Inputs watched
    input wire logic i_clock_mode_select,
    input wire logic [15:0] i_opcode,
    input wire logic i_opcode_valid,
    input wire logic [5:0] i_exc_mask,
    input wire fsw_load_t i_load,
    // Outputs watched
    input wire fsw_store_t o_store,
    input wire logic [15:0] o_fpu_status_word,
    input wire logic o_error_n,
    input wire logic o_exec_enable,
    input wire logic o_idle,
    input wire logic o_escape_seen
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // ****************************************
    // Properties
    // ****************************************
    property p_mirror;
        o_fpu_status_word[15] == o_fpu_status_word[7];
    endproperty
    a_mirror: assert property (p_mirror) else $error("busy mirror differs");
    property p_summary;
        o_fpu_status_word[7] == |(o_fpu_status_word[5:0] & ~$past(i_exc_mask));
    endproperty
    a_summary: assert property (p_summary) else $error("summary wrong");
    property p_error_on;
        o_fpu_status_word[7] |-> ##[0:1] !o_error_n;
    endproperty
    a_error_on: assert property (p_error_on) else $error("fault not raised");
    property p_error_off;
        !o_fpu_status_word[7] [*2] |-> o_error_n;
    endproperty
    a_error_off: assert property (p_error_off) else $error("fault stuck");
    // Two-cycle history keeps a mode switch from flagging a late idle exit
    property p_no_idle;
        !i_clock_mode_select && $past(!i_clock_mode_select) |-> o_exec_enable && !o_idle;
    endproperty
    a_no_idle: assert property (p_no_idle) else $error("idle in async mode");
    property p_wake;
        o_idle && i_opcode_valid && i_opcode[15:11] == 5'h1b |=> !o_idle;
    endproperty
    a_wake: assert property (p_wake) else $error("slow wake");
    property p_sticky;
        |($past(o_fpu_status_word[5:0]) & ~o_fpu_status_word[5:0]) |->
            $past(i_opcode_valid, 2) || $past(i_load.valid);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_escape;
        o_escape_seen == (i_opcode[15:11] == 5'h1b);
    endproperty
    a_escape: assert property (p_escape) else $error("escape decode");
    property p_store_acc;
        o_store.valid && o_store.to_acc |-> o_store.word == o_fpu_status_word;
    endproperty
    a_store_acc: assert property (p_store_acc) else $error("stored word");
    property p_store_pulse;
        o_store.valid |=> !o_store.valid;
    endproperty
    a_store_pulse: assert property (p_store_pulse) else $error("store pulse");

    c_fault: cover property (!o_error_n);
    c_idle: cover property (o_idle);
    c_store: cover property (o_store.valid && o_store.to_acc);
endmodule : fsw_status_word_props

bind fsw_status_word fsw_status_word_props u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_clock_mode_select(i_clock_mode_select),
    .i_opcode(i_opcode), .i_opcode_valid(i_opcode_valid), .i_exc_mask(i_exc_mask),
    .i_load(i_load), .o_store(o_store), .o_fpu_status_word(o_fpu_status_word),
    .o_error_n(o_error_n), .o_exec_enable(o_exec_enable), .o_idle(o_idle),
    .o_escape_seen(o_escape_seen)
);

// >>> testbench/tb.sv
// Self-checking bench for the status-word block.
// Assumes the host model as partner; memory loads are exercised by t_load.
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] %s exp=%h got=%h", nm, exp, got); end end

module tb;
    import fsw_pkg::*;
    logic i_clk;
    logic i_rst_n;
    logic i_clock_mode_select;
    logic [5:0] i_exc_mask;
    logic [15:0] opcode;
    logic opcode_valid;
    fsw_result_t result;
    fsw_load_t load;
    fsw_store_t o_store;
    logic [15:0] o_fpu_status_word;
    logic o_error_n;
    logic o_exec_enable;
    logic o_idle;
    logic o_escape_seen;
    int num_errors = 0;
    int tests_run = 0;

    fsw_host_model u_host (.i_clk(i_clk), .o_opcode(opcode), .o_opcode_valid(opcode_valid),
        .o_result(result), .o_load(load));
    fsw_status_word u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_clock_mode_select(i_clock_mode_select), .i_opcode(opcode),
        .i_opcode_valid(opcode_valid), .i_exc_mask(i_exc_mask), .i_result(result),
        .i_load(load), .o_store(o_store), .o_fpu_status_word(o_fpu_status_word),
        .o_error_n(o_error_n), .o_exec_enable(o_exec_enable), .o_idle(o_idle),
        .o_escape_seen(o_escape_seen));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task end_sim;
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // ****************************************
    // Scenarios
    // ****************************************
    task t_exception;
        fsw_result_t r;
        r = '0;
        r.exc = 6'h01;
        u_host.issue(16'hd8c1);
        u_host.complete(r, 2);
        `CHK("flag0", 1'b1, o_fpu_status_word[0])
        `CHK("summary", 2'b11, {o_fpu_status_word[15], o_fpu_status_word[7]})
        `CHK("fault", 1'b0, o_error_n)
        r.exc = 6'h00;
        u_host.issue(16'hd8c1);
        u_host.complete(r, 1);
        `CHK("sticky", 1'b1, o_fpu_status_word[0])
    endtask : t_exception

    task t_store_acc;
        int n;
        u_host.issue(16'hdfe0);
        for (n = 0; n < 8 && o_store.valid !== 1'b1; n++) @(negedge i_clk);
        if (n == 8) begin
            num_errors++;
            end_sim();
        end
        `CHK("to_acc", 1'b1, o_store.to_acc)
        `CHK("word", 16'h8081, o_store.word)
    endtask : t_store_acc

    task t_mask;
        i_exc_mask = 6'h3f;
        repeat (2) @(negedge i_clk);
        `CHK("masked", 3'b011, {o_fpu_status_word[7], o_error_n, o_fpu_status_word[0]})
        i_exc_mask = 6'h3e;
        repeat (2) @(negedge i_clk);
        `CHK("unmasked", 1'b0, o_error_n)
    endtask : t_mask

    task t_init;
        u_host.issue(16'hdbe3);
        repeat (3) @(negedge i_clk);
        `CHK("init word", 16'h0000, o_fpu_status_word)
        `CHK("init fault", 1'b1, o_error_n)
    endtask : t_init

    task t_stack_fault;
        fsw_result_t r;
        r = '0;
        r.exc = 6'h01;
        r.stack_fault = 1'b1;
        r.overflow = 1'b1;
        u_host.issue(16'hd8c1);
        u_host.complete(r, 3);
        `CHK("stack flag", 2'b11, {o_fpu_status_word[6], o_fpu_status_word[9]})
        u_host.issue(16'hdbe2);
        repeat (3) @(negedge i_clk);
        `CHK("cleared", 7'h00, {o_fpu_status_word[7], o_fpu_status_word[5:0]})
        `CHK("clear fault", 1'b1, o_error_n)
    endtask : t_stack_fault

    task t_compare;
        fsw_result_t r;
        r = '0;
        r.cc_write = 1'b1;
        r.cc = 4'b1010;
        r.pops = 2'd2;
        u_host.issue(16'hded9);
        u_host.complete(r, 2);
        `CHK("cc", 4'b1010, {o_fpu_status_word[14], o_fpu_status_word[10:8]})
        `CHK("top", 3'd2, o_fpu_status_word[13:11])
    endtask : t_compare

    task t_load;
        u_host.issue(16'hd920);
        u_host.load(16'h0841);
        `CHK("load word", 16'h88c1, o_fpu_status_word)
        `CHK("load fault", 1'b0, o_error_n)
        u_host.issue(16'hdd20);
        u_host.load(16'h8080);
        `CHK("restore word", 16'h0000, o_fpu_status_word)
        `CHK("restore fault", 1'b1, o_error_n)
    endtask : t_load

    task t_const;
        fsw_result_t r;
        r = '0;
        r.exc = 6'h3c;
        r.push = 1'b1;
        u_host.issue(16'hd9e8);
        u_host.complete(r, 1);
        `CHK("const word", 16'h3800, o_fpu_status_word)
    endtask : t_const

    task t_idle;
        fsw_result_t r;
        r = '0;
        u_host.issue(16'hd8c1);
        u_host.complete(r, 1);
        repeat (6) @(negedge i_clk);
        `CHK("async run", 2'b10, {o_exec_enable, o_idle})
        i_clock_mode_select = 1'b1;
        u_host.issue(16'hd8c1);
        u_host.complete(r, 1);
        `CHK("busy run", 1'b0, o_idle)
        repeat (3) @(negedge i_clk);
        `CHK("idle", 2'b01, {o_exec_enable, o_idle})
        u_host.issue(16'hd8c1);
        `CHK("wake", 1'b0, o_idle)
        u_host.complete(r, 1);
    endtask : t_idle

    initial begin
        i_rst_n = 1'b0;
        i_clock_mode_select = 1'b0;
        i_exc_mask = 6'h3e;
        repeat (3) @(negedge i_clk);
        i_rst_n = 1'b1;
        `CHK("reset word", 16'h0000, o_fpu_status_word)
        `CHK("reset fault", 1'b1, o_error_n)
        t_exception();
        t_store_acc();
        t_mask();
        t_init();
        t_stack_fault();
        t_init();
        t_compare();
        t_load();
        t_const();
        t_idle();
        repeat (2) @(negedge i_clk);
        end_sim();
    end
endmodule : tb
